// ==== hw/bqfac_cnt.v ====
// loadable down counter timing one sequencer phase
`timescale 1ns/10ps
module bqfac_cnt (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        load,
    input  wire [15:0] load_val,
    input  wire        dec,
    output wire        zero
);
    reg [15:0] cnt_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 16'h0000;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (dec && (cnt_ff != 16'h0000)) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end

    assign zero = (cnt_ff == 16'h0000);
endmodule

// ==== hw/bqfac_top.v ====
// apb control, status, debug and channel sequencer of the biquad accelerator
`timescale 1ns/10ps
`include "bqfac_map.vh"

// What this block does
// R1 - accelerator runs only while the global enable bit is set
// R2 - channels processed equal channel count field plus one, 0 to 23
// R3 - global bit 8 enables or disables dma transfers
// R4 - auto iterate loops to first channel, else idle after last channel
// R5 - save state stores each channel's delay elements to internal memory
// R6 - interrupt after every channel or only after all channels
// R7 - bit 12 selects 32-bit or 40-bit floating point
// R8 - three-bit field selects the rounding mode
// R9 - each channel cascades section count plus one biquads, 0 to 11
// R10 - window field sets samples per block, one means per sample
// R11 - read-only mac status shows multiplier and adder zero, inf, invalid
// R12 - status bits 0-3 show pointer load, coef load, mac, writeback
// R13 - status bit 4 high while one channel's state is saved
// R14 - software polls pointer load and save bits low after all done
// R15 - channel done bit sticky, cleared by read, granularity-independent
// R16 - all channels done bit sticky, cleared by read
// R17 - status bits 11-7 show current slot, zero is the last
// R18 - debug bit 0 enables debug mode
// R19 - debug bit 1 single-steps mac or holds data per memory access
// R20 - writing 1 to debug bit 2 releases mac, self clears next cycle
// R21 - debug bit 4 opens indirect memory access, bit 5 auto-increments
// R22 - step, hold and release act only in debug mode
module bqfac_top (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [7:0]             paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    input  wire [5:0]             mac_flags,
    input  wire [31:0]            mem_rdata,
    output reg                    mac_step,
    output reg                    hold_data,
    output reg                    irq,
    output reg                    save_wr,
    output reg  [4:0]             save_chan,
    output reg                    extended_float_sel,
    output reg  [2:0]             round_mode,
    output reg                    mem_we,
    output reg                    mem_re,
    output reg  [`BQ_DADDR_W-1:0] mem_addr,
    output reg  [31:0]            mem_wdata
);
    // ***********************************************************
    // sequencer states
    // ***********************************************************
    localparam [6:0] ST_IDLE = 7'b000_0001;
    localparam [6:0] ST_CPL  = 7'b000_0010;
    localparam [6:0] ST_LOAD = 7'b000_0100;
    localparam [6:0] ST_MAC  = 7'b000_1000;
    localparam [6:0] ST_WRBK = 7'b001_0000;
    localparam [6:0] ST_SAVE = 7'b010_0000;
    localparam [6:0] ST_NEXT = 7'b100_0000;

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = hit(a, `BQ_OFF_GCTL) | hit(a, `BQ_OFF_CCTL) |
                     hit(a, `BQ_OFF_MSTAT) | hit(a, `BQ_OFF_DSTAT) |
                     hit(a, `BQ_OFF_DBGCTL) | hit(a, `BQ_OFF_DBGADDR) |
                     hit(a, `BQ_OFF_DBGWR) | hit(a, `BQ_OFF_DBGRD);
        end
    endfunction

    // control registers
    reg        accel_enable_ff;
    reg [4:0]  channel_count_ff;
    reg        dma_enable_ff;
    reg        auto_iterate_ff;
    reg        save_state_ff;
    reg        per_channel_irq_ff;
    reg [3:0]  section_count_ff;
    reg [9:0]  block_size_ff;
    reg        debug_enable_ff;
    reg        step_or_hold_ff;
    reg        mac_release_ff;
    reg        local_mem_access_ff;
    reg        debug_addr_autoinc_ff;
    // status
    reg [5:0]  mac_stat_ff;
    reg        channel_done_ff;
    reg        all_channels_done_ff;
    reg [4:0]  current_slot_ff;
    // sequencer
    reg [6:0]  state_ff;
    reg [6:0]  nxt_state;
    reg [4:0]  chan_ff;
    reg [4:0]  nxt_chan;
    reg        cnt_load;
    reg [15:0] cnt_val;
    reg        chan_done_evt;
    reg        all_done_evt;
    reg        phase_en;
    reg [31:0] rd_mux;
    wire       cnt_zero;

    // ***********************************************************
    // apb decode
    // ***********************************************************
    wire apb_setup  = psel & ~penable;
    wire apb_access = psel & penable & pready;
    wire wr_acc     = apb_access & pwrite;
    wire rd_acc     = apb_access & ~pwrite;
    wire dbg_mem_on = debug_enable_ff & local_mem_access_ff;
    wire rd_dstat   = rd_acc & hit(paddr, `BQ_OFF_DSTAT);
    wire dbg_wr     = wr_acc & hit(paddr, `BQ_OFF_DBGWR) & dbg_mem_on;
    wire dbg_rd     = rd_acc & hit(paddr, `BQ_OFF_DBGRD) & dbg_mem_on;

    // ***********************************************************
    // derived sequencer quantities
    // ***********************************************************
    wire [15:0] sec_p1  = {12'h000, section_count_ff} + 16'h0001; // R9
    // a window of zero is treated as one sample to avoid a stuck phase
    wire [15:0] win_eff = (block_size_ff == 10'h000) ? 16'h0001 :
                          {6'h00, block_size_ff}; // R10
    wire [15:0] mac_len = sec_p1 * win_eff;
    wire [15:0] ld_len  = sec_p1 * `BQ_LD_PER_SEC;
    wire [15:0] sv_len  = sec_p1 * `BQ_SV_PER_SEC;
    wire        release_eff = mac_release_ff & debug_enable_ff; // R22
    // step and hold both freeze the mac; release lets one step through
    wire        mac_adv = (debug_enable_ff & step_or_hold_ff) ?
                          release_eff : 1'b1; // R19 R20
    wire        go = accel_enable_ff & dma_enable_ff; // R1 R3

    bqfac_cnt u_phase_cnt (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (cnt_load),
        .load_val (cnt_val),
        .dec      (phase_en),
        .zero     (cnt_zero)
    );

    // ***********************************************************
    // channel sequencer
    // ***********************************************************
    always @* begin
        nxt_state     = state_ff;
        nxt_chan      = chan_ff;
        cnt_load      = 1'b0;
        cnt_val       = 16'h0000;
        chan_done_evt = 1'b0;
        all_done_evt  = 1'b0;
        // memory phases stall while dma is off instead of aborting
        phase_en      = dma_enable_ff; // R3
        case (state_ff)
            ST_IDLE: begin
                phase_en = 1'b0;
                if (go) begin // R1
                    nxt_state = ST_CPL;
                    nxt_chan  = 5'h00;
                    cnt_load  = 1'b1;
                    cnt_val   = `BQ_CPL_CYC - 16'h0001;
                end
            end
            ST_CPL: begin
                if (cnt_zero && phase_en) begin
                    nxt_state = ST_LOAD;
                    cnt_load  = 1'b1;
                    cnt_val   = ld_len - 16'h0001;
                end
            end
            ST_LOAD: begin
                if (cnt_zero && phase_en) begin
                    nxt_state = ST_MAC;
                    cnt_load  = 1'b1;
                    cnt_val   = mac_len - 16'h0001; // R9 R10
                end
            end
            ST_MAC: begin
                phase_en = mac_adv; // R19
                if (cnt_zero && phase_en) begin
                    nxt_state = ST_WRBK;
                    cnt_load  = 1'b1;
                    cnt_val   = `BQ_WB_CYC - 16'h0001;
                end
            end
            ST_WRBK: begin
                if (cnt_zero && phase_en) begin
                    cnt_load = 1'b1;
                    if (save_state_ff) begin // R5
                        nxt_state = ST_SAVE;
                        cnt_val   = sv_len - 16'h0001;
                    end else begin
                        nxt_state = ST_NEXT;
                    end
                end
            end
            ST_SAVE: begin
                if (cnt_zero && phase_en) begin
                    nxt_state = ST_NEXT;
                end
            end
            ST_NEXT: begin
                phase_en      = 1'b0;
                chan_done_evt = 1'b1;
                cnt_load      = 1'b1;
                cnt_val       = `BQ_CPL_CYC - 16'h0001;
                if (chan_ff >= channel_count_ff) begin // R2
                    all_done_evt = 1'b1;
                    nxt_chan     = 5'h00;
                    nxt_state    = auto_iterate_ff ? ST_CPL : ST_IDLE; // R4
                end else begin
                    nxt_chan  = chan_ff + 5'h01;
                    nxt_state = ST_CPL;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                phase_en  = 1'b0;
            end
        endcase
        // clearing the enable abandons the frame at once
        if (!accel_enable_ff) begin // R1
            nxt_state     = ST_IDLE;
            nxt_chan      = 5'h00;
            chan_done_evt = 1'b0;
            all_done_evt  = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff        <= ST_IDLE;
            chan_ff         <= 5'h00;
            current_slot_ff <= 5'h00;
        end else begin
            state_ff        <= nxt_state;
            chan_ff         <= nxt_chan;
            current_slot_ff <= channel_count_ff - nxt_chan; // R17
        end
    end

    // ***********************************************************
    // status capture
    // ***********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_mac_stat
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mac_stat_ff[gi] <= 1'b0;
                end else begin
                    mac_stat_ff[gi] <= mac_flags[gi]; // R11
                end
            end
        end
    endgenerate

    // only bits that the read returned are cleared; a new event wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_done_ff      <= 1'b0;
            all_channels_done_ff <= 1'b0;
        end else begin
            channel_done_ff <= chan_done_evt | (channel_done_ff &
                ~(rd_dstat & prdata[`BQ_D_WDONE])); // R15
            all_channels_done_ff <= all_done_evt | (all_channels_done_ff &
                ~(rd_dstat & prdata[`BQ_D_ACDONE])); // R16
        end
    end

    // ***********************************************************
    // register writes
    // ***********************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accel_enable_ff       <= 1'b0;
            channel_count_ff      <= 5'h00;
            dma_enable_ff         <= 1'b0;
            auto_iterate_ff       <= 1'b0;
            save_state_ff         <= 1'b0;
            per_channel_irq_ff    <= 1'b0;
            extended_float_sel    <= 1'b0;
            round_mode            <= 3'h0;
            section_count_ff      <= 4'h0;
            block_size_ff         <= 10'h000;
            debug_enable_ff       <= 1'b0;
            step_or_hold_ff       <= 1'b0;
            mac_release_ff        <= 1'b0;
            local_mem_access_ff   <= 1'b0;
            debug_addr_autoinc_ff <= 1'b0;
        end else begin
            mac_release_ff <= 1'b0; // R20
            if (wr_acc && hit(paddr, `BQ_OFF_GCTL)) begin
                accel_enable_ff <= pwdata[`BQ_G_EN]; // R1
                // out-of-range counts are clamped to the last legal value
                channel_count_ff <=
                    (pwdata[`BQ_G_NCH_HI:`BQ_G_NCH_LO] > `BQ_NCH_MAX) ?
                    `BQ_NCH_MAX : pwdata[`BQ_G_NCH_HI:`BQ_G_NCH_LO]; // R2
                dma_enable_ff      <= pwdata[`BQ_G_DMAEN]; // R3
                auto_iterate_ff    <= pwdata[`BQ_G_CAI]; // R4
                save_state_ff      <= pwdata[`BQ_G_SS]; // R5
                per_channel_irq_ff <= pwdata[`BQ_G_CCINTR]; // R6
                extended_float_sel <= pwdata[`BQ_G_FORTY]; // R7
                round_mode <= pwdata[`BQ_G_RND_HI:`BQ_G_RND_LO]; // R8
            end
            if (wr_acc && hit(paddr, `BQ_OFF_CCTL)) begin
                section_count_ff <=
                    (pwdata[`BQ_C_SEC_HI:`BQ_C_SEC_LO] > `BQ_SEC_MAX) ?
                    `BQ_SEC_MAX : pwdata[`BQ_C_SEC_HI:`BQ_C_SEC_LO]; // R9
                block_size_ff <= pwdata[`BQ_C_WIN_HI:`BQ_C_WIN_LO]; // R10
            end
            if (wr_acc && hit(paddr, `BQ_OFF_DBGCTL)) begin
                debug_enable_ff       <= pwdata[`BQ_DB_MODE]; // R18
                step_or_hold_ff       <= pwdata[`BQ_DB_HLD]; // R19
                mac_release_ff        <= pwdata[`BQ_DB_RUN]; // R20
                local_mem_access_ff   <= pwdata[`BQ_DB_MEM]; // R21
                debug_addr_autoinc_ff <= pwdata[`BQ_DB_INC]; // R21
            end
        end
    end

    // ***********************************************************
    // indirect memory access
    // ***********************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr  <= {`BQ_DADDR_W{1'b0}};
            mem_wdata <= `BQ_RST_REG;
            mem_we    <= 1'b0;
            mem_re    <= 1'b0;
        end else begin
            mem_we <= dbg_wr; // R21
            mem_re <= dbg_rd; // R21
            if (dbg_wr) begin
                mem_wdata <= pwdata;
            end
            if (wr_acc && hit(paddr, `BQ_OFF_DBGADDR)) begin
                mem_addr <= pwdata[`BQ_DADDR_W-1:0];
            end else if ((dbg_wr || dbg_rd) && debug_addr_autoinc_ff) begin
                mem_addr <= mem_addr + {{(`BQ_DADDR_W-1){1'b0}}, 1'b1}; // R21
            end
        end
    end

    // ***********************************************************
    // datapath strobes and interrupt
    // ***********************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_step  <= 1'b0;
            hold_data <= 1'b0;
            irq       <= 1'b0;
            save_wr   <= 1'b0;
            save_chan <= 5'h00;
        end else begin
            mac_step  <= (state_ff == ST_MAC) & mac_adv & accel_enable_ff;
            hold_data <= dbg_mem_on & step_or_hold_ff; // R19 R22
            irq       <= per_channel_irq_ff ? chan_done_evt :
                         all_done_evt; // R6
            save_wr   <= (state_ff == ST_SAVE) & dma_enable_ff; // R5
            save_chan <= chan_ff;
        end
    end

    // ***********************************************************
    // apb read path, one wait-free access cycle
    // ***********************************************************
    always @* begin
        rd_mux = `BQ_RST_REG;
        case (1'b1)
            hit(paddr, `BQ_OFF_GCTL): begin
                rd_mux[`BQ_G_EN]                   = accel_enable_ff;
                rd_mux[`BQ_G_NCH_HI:`BQ_G_NCH_LO]  = channel_count_ff;
                rd_mux[`BQ_G_DMAEN]                = dma_enable_ff;
                rd_mux[`BQ_G_CAI]                  = auto_iterate_ff;
                rd_mux[`BQ_G_SS]                   = save_state_ff;
                rd_mux[`BQ_G_CCINTR]               = per_channel_irq_ff;
                rd_mux[`BQ_G_FORTY]                = extended_float_sel;
                rd_mux[`BQ_G_RND_HI:`BQ_G_RND_LO]  = round_mode;
            end
            hit(paddr, `BQ_OFF_CCTL): begin
                rd_mux[`BQ_C_SEC_HI:`BQ_C_SEC_LO]  = section_count_ff;
                rd_mux[`BQ_C_WIN_HI:`BQ_C_WIN_LO]  = block_size_ff;
            end
            hit(paddr, `BQ_OFF_MSTAT): begin
                rd_mux[5:0] = mac_stat_ff; // R11
            end
            hit(paddr, `BQ_OFF_DSTAT): begin
                rd_mux[`BQ_D_CPL]    = (state_ff == ST_CPL); // R12 R14
                rd_mux[`BQ_D_LOAD]   = (state_ff == ST_LOAD); // R12
                rd_mux[`BQ_D_MAC]    = (state_ff == ST_MAC); // R12
                rd_mux[`BQ_D_WRBK]   = (state_ff == ST_WRBK); // R12
                rd_mux[`BQ_D_SAVE]   = (state_ff == ST_SAVE); // R13
                rd_mux[`BQ_D_WDONE]  = channel_done_ff; // R15
                rd_mux[`BQ_D_ACDONE] = all_channels_done_ff; // R16
                rd_mux[`BQ_D_SLOT_HI:`BQ_D_SLOT_LO] = current_slot_ff; // R17
            end
            hit(paddr, `BQ_OFF_DBGCTL): begin
                rd_mux[`BQ_DB_MODE] = debug_enable_ff;
                rd_mux[`BQ_DB_HLD]  = step_or_hold_ff;
                rd_mux[`BQ_DB_RUN]  = mac_release_ff;
                rd_mux[`BQ_DB_MEM]  = local_mem_access_ff;
                rd_mux[`BQ_DB_INC]  = debug_addr_autoinc_ff;
            end
            hit(paddr, `BQ_OFF_DBGADDR): begin
                rd_mux[`BQ_DADDR_W-1:0] = mem_addr;
            end
            hit(paddr, `BQ_OFF_DBGRD): begin
                rd_mux = dbg_mem_on ? mem_rdata : `BQ_RST_REG;
            end
            default: begin
                rd_mux = `BQ_RST_REG;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `BQ_RST_REG;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~mapped(paddr);
            if (apb_setup) begin
                prdata <= pwrite ? `BQ_RST_REG : rd_mux;
            end
        end
    end
endmodule

// ==== inc/bqfac_map.vh ====
// register map, field positions, reset values and phase timing of the biquad control block
`ifndef BQFAC_MAP_VH
`define BQFAC_MAP_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define BQ_OFF_GCTL      8'h00
`define BQ_OFF_CCTL      8'h04
`define BQ_OFF_MSTAT     8'h08
`define BQ_OFF_DSTAT     8'h0C
`define BQ_OFF_DBGCTL    8'h10
`define BQ_OFF_DBGADDR   8'h14
`define BQ_OFF_DBGWR     8'h18
`define BQ_OFF_DBGRD     8'h1C

// ***************************************************************
// global control fields
// ***************************************************************
`define BQ_G_EN          0
`define BQ_G_NCH_LO      1
`define BQ_G_NCH_HI      5
`define BQ_G_DMAEN       8
`define BQ_G_CAI         9
`define BQ_G_SS          10
`define BQ_G_CCINTR      11
`define BQ_G_FORTY       12
`define BQ_G_RND_LO      14
`define BQ_G_RND_HI      16
`define BQ_NCH_MAX       5'h17

// ***************************************************************
// channel control fields
// ***************************************************************
`define BQ_C_SEC_LO      0
`define BQ_C_SEC_HI      3
`define BQ_C_WIN_LO      14
`define BQ_C_WIN_HI      23
`define BQ_SEC_MAX       4'hB

// ***************************************************************
// dma status fields
// ***************************************************************
`define BQ_D_CPL         0
`define BQ_D_LOAD        1
`define BQ_D_MAC         2
`define BQ_D_WRBK        3
`define BQ_D_SAVE        4
`define BQ_D_WDONE       5
`define BQ_D_ACDONE      6
`define BQ_D_SLOT_LO     7
`define BQ_D_SLOT_HI     11

// ***************************************************************
// debug control fields
// ***************************************************************
`define BQ_DB_MODE       0
`define BQ_DB_HLD        1
`define BQ_DB_RUN        2
`define BQ_DB_MEM        4
`define BQ_DB_INC        5
`define BQ_DADDR_W       12

// ***************************************************************
// reset values and phase timing in accelerator cycles
// ***************************************************************
`define BQ_RST_REG       32'h0000_0000
`define BQ_CPL_CYC       16'h0004
`define BQ_LD_PER_SEC    16'h0007
`define BQ_WB_CYC        16'h0002
`define BQ_SV_PER_SEC    16'h0002

`endif

// ==== tb/bqfac_far.sv ====
// far side model: datapath flags and debug memory read port
`timescale 1ns/10ps
module bqfac_far (
    input  wire        pclk,
    input  wire [5:0]  flags_in,
    input  wire [11:0] mem_addr,
    output reg  [5:0]  mac_flags,
    output wire [31:0] mem_rdata
);
    // address-dependent pattern so a stale address shows up
    assign mem_rdata = {20'h0_0000, mem_addr} ^ 32'h5a5a_5a5a;
    initial mac_flags = 6'h00;
    always @(posedge pclk) begin
        mac_flags <= flags_in;
    end
endmodule

// ==== tb/bqfac_monitor.sv ====
// port-level assertions of the biquad control block
`timescale 1ns/10ps
module bqfac_monitor (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq,
    input wire        save_wr,
    input wire [4:0]  save_chan,
    input wire        extended_float_sel,
    input wire [2:0]  round_mode,
    input wire        mem_we,
    input wire        mem_re
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_gwr;
        psel && penable && pready && pwrite && paddr == 8'h00;
    endsequence
    a_ready_next: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_err_unmapped: assert property ((s_setup and paddr > 8'h1C) |=> pslverr)
        else $error("no error on unmapped address");
    a_irq_pulse: assert property (irq |=> !irq)
        else $error("irq longer than one cycle");
    a_float_copy: assert property (s_gwr |=>
        extended_float_sel == $past(pwdata[12]))
        else $error("float select not taken");
    a_round_copy: assert property (s_gwr |=>
        round_mode == $past(pwdata[16:14]))
        else $error("round mode not taken");
    a_we_cause: assert property (mem_we |->
        $past(psel && penable && pwrite && paddr == 8'h18))
        else $error("memory write without data write");
    a_re_cause: assert property (mem_re |->
        $past(psel && penable && !pwrite && paddr == 8'h1C))
        else $error("memory read without data read");
    a_save_chan_hold: assert property (save_wr && $past(save_wr) |->
        $stable(save_chan))
        else $error("save channel moved during save");
endmodule
bind bqfac_top bqfac_monitor bqfac_monitor_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .save_wr(save_wr), .save_chan(save_chan),
    .extended_float_sel(extended_float_sel), .round_mode(round_mode),
    .mem_we(mem_we), .mem_re(mem_re));

// ==== tb/test_biquad_filter_accel_control.sv ====
// self-checking bench of the biquad control block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module test_biquad_filter_accel_control;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [7:0]  paddr = 0;
    reg  [31:0] pwdata = 0, rd;
    reg  [5:0]  flags = 0;
    reg         err;
    wire [31:0] prdata, mem_rdata, mem_wdata;
    wire [11:0] mem_addr;
    wire [5:0]  mac_flags;
    wire [4:0]  save_chan;
    wire [2:0]  round_mode;
    wire        pready, pslverr, mac_step, hold_data, irq, save_wr;
    wire        xf, mem_we, mem_re;
    integer     checks = 0, n_errors = 0, n_irq = 0, i, k;
    bqfac_top bqfac_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_flags(mac_flags), .mem_rdata(mem_rdata), .mac_step(mac_step),
        .hold_data(hold_data), .irq(irq), .save_wr(save_wr),
        .save_chan(save_chan), .extended_float_sel(xf),
        .round_mode(round_mode), .mem_we(mem_we), .mem_re(mem_re),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    bqfac_far bqfac_far_i (.pclk(pclk), .flags_in(flags),
        .mem_addr(mem_addr), .mac_flags(mac_flags), .mem_rdata(mem_rdata));
    initial forever #2.5 pclk = ~pclk;
    always @(posedge pclk) if (irq === 1'b1) n_irq++;
    // ***************************************************************
    // bus tasks
    // ***************************************************************
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
        begin
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            for (k = 0; pready !== 1'b1; k++) begin
                @(posedge pclk);
                if (k > 50) begin n_errors++; stop_test; end
            end
            rd = prdata;
            err = pslverr;
            psel <= 0; penable <= 0;
            @(posedge pclk);
        end
    endtask
    // software waits for masked status bits to reach a value
    task poll(input reg [31:0] m, input reg [31:0] v);
        integer n;
        begin
            rd = ~v;
            for (n = 0; (rd & m) !== v; n++) begin
                if (n > 100) begin n_errors++; stop_test; end
                apb(0, 8'h0C, 0);
            end
        end
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (i = 0; i < 8; i++) begin apb(0, i * 4, 0); `CHK(rd, 0) end
        apb(1, 8'h40, 32'hffff_ffff);
        `CHK(err, 1'b1)
        $display("reset and map test done");
        apb(1, 8'h00, 32'h0001_503E);
        apb(0, 8'h00, 0);
        `CHK(rd, 32'h0001_502E)
        `CHK(xf, 1'b1)
        for (i = 0; i < 8; i++) begin
            apb(1, 8'h00, i << 14);
            `CHK(round_mode, i[2:0])
        end
        apb(1, 8'h04, 32'h00ff_c00f);
        apb(0, 8'h04, 0);
        `CHK(rd, 32'h00ff_c00b)
        flags <= 6'h2A;
        apb(1, 8'h08, 32'hffff_ffff);
        apb(0, 8'h08, 0);
        `CHK(rd, 32'h0000_002A)
        $display("config test done");
        apb(1, 8'h04, 32'h0000_4000);
        for (i = 0; i < 2; i++) begin
            n_irq = 0;
            apb(1, 8'h00, i ? 32'h0000_0D03 : 32'h0000_0503);
            poll(32'h40, 32'h40);
            `CHK(rd[5], 1'b1)
            apb(0, 8'h0C, 0);
            `CHK(rd[6:5], 2'b00)
            poll(32'h11, 0);
            `CHK(n_irq, i + 1)
            apb(1, 8'h00, 0);
        end
        $display("run test done");
        apb(1, 8'h10, 32'h0000_0031);
        apb(1, 8'h14, 32'h0000_0005);
        apb(1, 8'h18, 32'hcafe_0001);
        `CHK(mem_wdata, 32'hcafe_0001)
        `CHK(mem_addr, 12'h006)
        apb(0, 8'h1C, 0);
        `CHK(rd, 32'h5a5a_5a5c)
        apb(1, 8'h10, 32'h0000_0013);
        @(posedge pclk);
        `CHK(hold_data, 1'b1)
        apb(1, 8'h10, 32'h0000_0005);
        apb(0, 8'h10, 0);
        `CHK(rd, 32'h0000_0001)
        // memory access and hold on, debug off: hold must stay low
        apb(1, 8'h10, 32'h0000_0016);
        @(posedge pclk);
        `CHK(hold_data, 1'b0)
        $display("debug test done");
        stop_test;
    end
endmodule
